// ===== rtl/pft_pkg.sv
// pft_pkg: constants for the program flow and trap execution block
// assumes a 16-bit word machine with byte addresses, stack in memory
package pft_pkg;
	localparam int unsigned WORD_W = 16;
	// trap vector addresses (octal)
	localparam logic [15:0] VEC_ILLEGAL = 16'o4;
	localparam logic [15:0] VEC_RESERVED = 16'o10;
	localparam logic [15:0] VEC_BREAKPOINT = 16'o14;
	localparam logic [15:0] VEC_IO = 16'o20;
	localparam logic [15:0] VEC_EMULATOR = 16'o30;
	localparam logic [15:0] VEC_SOFTWARE = 16'o34;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	// opcode patterns
	localparam logic [15:0] OPC_JUMP = 16'o000100;
	localparam logic [15:0] MSK_JUMP = 16'o177700;
	localparam logic [15:0] OPC_CALL = 16'o004000;
	localparam logic [15:0] MSK_CALL = 16'o177000;
	localparam logic [15:0] OPC_RET = 16'o000200;
	localparam logic [15:0] MSK_RET = 16'o177770;
	localparam logic [15:0] OPC_LOOP = 16'o077000;
	localparam logic [15:0] MSK_LOOP = 16'o177000;
	localparam logic [15:0] OPC_EMT = 16'o104000;
	localparam logic [15:0] MSK_EMT = 16'o177400;
	localparam logic [15:0] OPC_SWT = 16'o104400;
	localparam logic [15:0] OPC_BPT = 16'o000003;
	localparam logic [15:0] OPC_IOT = 16'o000004;
	localparam logic [15:0] OPC_RTI = 16'o000002;
	localparam logic [15:0] OPC_RTT = 16'o000006;
	localparam logic [15:0] OPC_MARK = 16'o006400;
	localparam logic [15:0] MSK_MARK = 16'o177700;
	localparam logic [15:0] PSW_RESET = 16'h0000;
	// status word fields
	localparam int unsigned PSW_CM_HI = 15;
	localparam int unsigned PSW_CM_LO = 14;
	localparam int unsigned PSW_PM_HI = 13;
	localparam int unsigned PSW_PM_LO = 12;
	localparam int unsigned PSW_REGSET = 11;
	localparam int unsigned PSW_TRACE = 4;
	localparam logic [1:0] MODE_KERNEL = 2'b00;
	localparam logic [1:0] MODE_SUPER = 2'b01;
	localparam logic [1:0] MODE_USER = 2'b11;
	localparam logic [2:0] REG_FIVE = 3'd5;
	localparam logic [2:0] REG_SP = 3'd6;
	localparam logic [2:0] REG_PC = 3'd7;
	localparam logic [2:0] MODE0 = 3'd0;
	localparam logic [2:0] MODE_AUTOINC_DEF = 3'd3;
	typedef enum logic [3:0] {
		PFT_IDLE = 4'b0000,
		PFT_PUSH1 = 4'b0001,
		PFT_PUSH2 = 4'b0011,
		PFT_VEC1 = 4'b0010,
		PFT_VEC2 = 4'b0110,
		PFT_POP1 = 4'b0111,
		PFT_POP2 = 4'b0101,
		PFT_DONE = 4'b0100
	} pft_state_t;
	typedef enum logic [2:0] {
		OPK_CALL = 3'd0,
		OPK_TRAP = 3'd1,
		OPK_RET = 3'd2,
		OPK_RTI = 3'd3,
		OPK_RTT = 3'd4,
		OPK_MARK = 3'd5
	} pft_kind_t;
endpackage : pft_pkg

// ===== rtl/pft_exec.sv
// pft_exec: execution of jump, call, return, loop, trap and mark ops
// assumes a decoder supplies the instruction word and the computed
// destination address; memory answers a read while its strobe stands
//
// Summary of operation
// - jump loads pc; mode 0 traps vector 4
// - register deferred jump goes to register value
// - call: temp, push link, link=pc, pc=temp
// - call with mode 0 traps vector 10
// - call pc via (sp)+ deferred swaps stack top
// - call through pc changes only sp, pc
// - return: pc from register, pop into register
// - loop op decrements, branches back if nonzero
// - traps push status, pc; load vector pair
// - opcodes 104000-104377 trap through 30/32
// - opcodes 104400-104777 trap through 34/36
// - breakpoint trap uses vector 14/16
// - io trap uses vector 20/22
// - interrupt return pops pc, status; trace now
// - trap return delays trace one instruction
// - returned mode fields limited by current mode
// - register set bit sticky outside kernel
// - mark sets sp, pc=r5, pops r5
// - trace bit 4 traps via 14 after instruction
// - active stack chosen by current mode
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module pft_exec
	import pft_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire logic [15:0] instr_in,
	input wire logic [15:0] dest_in,
	input wire logic [15:0] mem_rdata_in,
	output logic busy_out,
	output logic done_out,
	output logic trace_trap_out,
	output logic mem_rd_out,
	output logic mem_wr_out,
	output logic mem_data_space_out,
	output logic [15:0] mem_addr_out,
	output logic [15:0] mem_wdata_out,
	output logic [15:0] pc_out,
	output logic [15:0] psw_out,
	output logic [15:0] sp_out,
	output logic [1:0] stack_mode_out
);
	typedef struct packed {
		pft_state_t st;
		pft_kind_t kind;
		logic [15:0] pc;
		logic [15:0] processor_status_word;
		logic [15:0] tmp;
		logic [15:0] vec;
		logic [5:0][15:0] gpr;
		logic [15:0] sp_k;
		logic [15:0] sp_s;
		logic [15:0] sp_u;
		logic [2:0] link;
		logic swap;
		logic busy;
		logic done;
		logic trace;
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] sp;
		logic dspace;
	} pft_state_reg_t;

	pft_state_reg_t s_q, s_d;

	// register file read including sp and pc
	function automatic logic [15:0] reg_rd(input pft_state_reg_t s,
			input logic [2:0] r);
		logic [15:0] v;
		v = s.pc;
		if (r == REG_SP) begin
			v = sp_sel(s);
		end else if (r != REG_PC) begin
			v = s.gpr[r];
		end
		return v;
	endfunction : reg_rd

	// active stack pointer from the current mode field
	function automatic logic [15:0] sp_sel(input pft_state_reg_t s);
		logic [15:0] v;
		v = s.sp_k;
		case (s.processor_status_word[PSW_CM_HI:PSW_CM_LO])
			MODE_SUPER: v = s.sp_s;
			MODE_USER: v = s.sp_u;
			default: v = s.sp_k;
		endcase
		return v;
	endfunction : sp_sel

	// write into register file, sp goes to the active stack
	function automatic pft_state_reg_t reg_wr(input pft_state_reg_t s,
			input logic [2:0] r, input logic [15:0] v);
		pft_state_reg_t o;
		o = s;
		if (r == REG_PC) begin
			o.pc = v;
		end else if (r == REG_SP) begin
			case (s.processor_status_word[PSW_CM_HI:PSW_CM_LO])
				MODE_SUPER: o.sp_s = v;
				MODE_USER: o.sp_u = v;
				default: o.sp_k = v;
			endcase
		end else begin
			o.gpr[r] = v;
		end
		return o;
	endfunction : reg_wr

	// status word restore with mode protection
	function automatic logic [15:0] psw_restore(input logic [15:0] cur,
			input logic [15:0] nw);
		logic [15:0] v;
		logic [1:0] cm;
		v = nw;
		cm = cur[PSW_CM_HI:PSW_CM_LO];
		if (cm != MODE_KERNEL) begin
			// only modes at or below current may be loaded
			v[PSW_CM_HI:PSW_CM_LO] = nw[PSW_CM_HI:PSW_CM_LO] | cm;
			v[PSW_PM_HI:PSW_PM_LO] = nw[PSW_PM_HI:PSW_PM_LO] | cm;
			v[PSW_REGSET] = nw[PSW_REGSET] | cur[PSW_REGSET];
		end
		return v;
	endfunction : psw_restore

	logic [2:0] dmode;
	logic [2:0] dreg;
	logic [15:0] cnt;
	logic [15:0] sp_now;

	// main sequencer
	always_comb begin
		s_d = s_q;
		dmode = instr_in[5:3];
		dreg = instr_in[2:0];
		cnt = 16'h0000;
		sp_now = sp_sel(s_q);
		s_d.done = 1'b0;
		s_d.trace = 1'b0;
		s_d.rd = 1'b0;
		s_d.wr = 1'b0;
		case (s_q.st)
			PFT_IDLE: begin
				if (start_in) begin
					s_d.busy = 1'b1;
					s_d.st = PFT_PUSH1;
					s_d.kind = OPK_TRAP;
					s_d.swap = 1'b0;
					if ((instr_in & MSK_JUMP) == OPC_JUMP) begin
						if (dmode == MODE0) begin
							s_d.vec = VEC_ILLEGAL;
						end else begin
							// dest already resolves deferred register
							s_d.pc = dest_in;
							s_d.st = PFT_DONE;
						end
					end else if ((instr_in & MSK_CALL) == OPC_CALL) begin
						if (dmode == MODE0) begin
							s_d.vec = VEC_RESERVED;
						end else begin
							s_d.kind = OPK_CALL;
							s_d.tmp = dest_in;
							s_d.link = instr_in[8:6];
							s_d.swap = (instr_in[8:6] == REG_PC) &&
								(dmode == MODE_AUTOINC_DEF) &&
								(dreg == REG_SP);
							s_d.st = PFT_PUSH2;
							s_d.wr = 1'b1;
							s_d.addr = sp_now - WORD_STEP;
							s_d.wdata = reg_rd(s_q, instr_in[8:6]);
							if (s_d.swap) begin
								// pop and push cancel, sp stays put
								s_d.addr = sp_now;
								s_d.wdata = s_q.pc;
							end else begin
								s_d = reg_wr(s_d, REG_SP, sp_now - WORD_STEP);
							end
						end
					end else if ((instr_in & MSK_RET) == OPC_RET) begin
						s_d.kind = OPK_RET;
						s_d.link = dreg;
						s_d.pc = reg_rd(s_q, dreg);
						s_d.st = PFT_POP2;
						s_d.rd = 1'b1;
						s_d.addr = sp_now;
					end else if ((instr_in & MSK_LOOP) == OPC_LOOP) begin
						cnt = reg_rd(s_q, instr_in[8:6]) - ONE_WORD;
						s_d = reg_wr(s_d, instr_in[8:6], cnt);
						if (cnt != 16'h0000) begin
							s_d.pc = s_q.pc - {9'h000, instr_in[5:0], 1'b0};
						end
						s_d.st = PFT_DONE;
					end else if ((instr_in & MSK_MARK) == OPC_MARK) begin
						s_d.kind = OPK_MARK;
						cnt = s_q.pc + {9'h000, instr_in[5:0], 1'b0};
						s_d.pc = s_q.gpr[REG_FIVE];
						s_d.link = REG_FIVE;
						s_d.st = PFT_POP2;
						s_d.rd = 1'b1;
						s_d.addr = cnt;
						s_d = reg_wr(s_d, REG_SP, cnt);
					end else if ((instr_in & MSK_EMT) == OPC_EMT) begin
						s_d.vec = VEC_EMULATOR;
					end else if ((instr_in & MSK_EMT) == OPC_SWT) begin
						s_d.vec = VEC_SOFTWARE;
					end else if (instr_in == OPC_BPT) begin
						s_d.vec = VEC_BREAKPOINT;
					end else if (instr_in == OPC_IOT) begin
						s_d.vec = VEC_IO;
					end else if (instr_in == OPC_RTI || instr_in == OPC_RTT) begin
						s_d.kind = OPK_RTT;
						if (instr_in == OPC_RTI) begin
							s_d.kind = OPK_RTI;
						end
						s_d.st = PFT_POP1;
						s_d.rd = 1'b1;
						s_d.addr = sp_now;
					end else begin
						s_d.vec = VEC_RESERVED;
					end
					if (s_d.st == PFT_PUSH1) begin
						// trap: push status word first
						s_d.st = PFT_PUSH2;
						s_d.wr = 1'b1;
						s_d.addr = sp_now - WORD_STEP;
						s_d.wdata = s_q.processor_status_word;
						s_d = reg_wr(s_d, REG_SP, sp_now - WORD_STEP);
					end
				end
			end
			PFT_PUSH2: begin
				if (s_q.kind == OPK_CALL) begin
					if (!s_q.swap) begin
						s_d = reg_wr(s_d, s_q.link, s_q.pc);
					end
					s_d.pc = s_q.tmp;
					s_d.st = PFT_DONE;
				end else begin
					s_d.wr = 1'b1;
					s_d.addr = sp_now - WORD_STEP;
					s_d.wdata = s_q.pc;
					s_d = reg_wr(s_d, REG_SP, sp_now - WORD_STEP);
					s_d.st = PFT_VEC1;
				end
			end
			PFT_VEC1: begin
				s_d.rd = 1'b1;
				s_d.addr = s_q.vec;
				s_d.st = PFT_VEC2;
			end
			PFT_VEC2: begin
				if (s_q.rd && s_q.addr == s_q.vec) begin
					s_d.tmp = mem_rdata_in;
					s_d.rd = 1'b1;
					s_d.addr = s_q.vec + WORD_STEP;
				end else begin
					s_d.pc = s_q.tmp;
					s_d.processor_status_word = mem_rdata_in;
					s_d.st = PFT_DONE;
				end
			end
			PFT_POP1: begin
				s_d.pc = mem_rdata_in;
				s_d.rd = 1'b1;
				s_d.addr = sp_now + WORD_STEP;
				s_d = reg_wr(s_d, REG_SP, sp_now + WORD_STEP);
				s_d.st = PFT_POP2;
			end
			PFT_POP2: begin
				s_d = reg_wr(s_d, REG_SP, sp_now + WORD_STEP);
				if (s_q.kind == OPK_RTI || s_q.kind == OPK_RTT) begin
					s_d.processor_status_word = psw_restore(s_q.processor_status_word, mem_rdata_in);
				end else begin
					s_d = reg_wr(s_d, s_q.link, mem_rdata_in);
				end
				s_d.st = PFT_DONE;
			end
			PFT_DONE: begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.st = PFT_IDLE;
				// trace after rti at once, after rtt one instruction later
				if (s_q.processor_status_word[PSW_TRACE] && s_q.kind != OPK_RTT) begin
					s_d.trace = 1'b1;
				end
				if (s_d.trace) begin
					s_d.kind = OPK_TRAP;
					s_d.vec = VEC_BREAKPOINT;
					s_d.busy = 1'b1;
					s_d.done = 1'b0;
					s_d.st = PFT_PUSH2;
					s_d.wr = 1'b1;
					s_d.addr = sp_now - WORD_STEP;
					s_d.wdata = s_q.processor_status_word;
					s_d = reg_wr(s_d, REG_SP, sp_now - WORD_STEP);
				end
				if (s_q.kind == OPK_RTT) begin
					s_d.kind = OPK_TRAP;
				end
			end
			default: s_d.st = PFT_IDLE;
		endcase
		// registered copies so these outputs come from flops
		s_d.sp = sp_sel(s_d);
		s_d.dspace = s_d.rd | s_d.wr;
		if (srst_in) begin
			s_d = '0;
			s_d.st = PFT_IDLE;
			s_d.processor_status_word = PSW_RESET;
		end
	end

	// state register
	always_ff @(posedge mclk_in) begin
		s_q <= s_d;
	end

	// outputs straight from state flops
	assign busy_out = s_q.busy;
	assign done_out = s_q.done;
	assign trace_trap_out = s_q.trace;
	assign mem_rd_out = s_q.rd;
	assign mem_wr_out = s_q.wr;
	assign mem_data_space_out = s_q.dspace;
	assign mem_addr_out = s_q.addr;
	assign mem_wdata_out = s_q.wdata;
	assign pc_out = s_q.pc;
	assign psw_out = s_q.processor_status_word;
	assign sp_out = s_q.sp;
	assign stack_mode_out = s_q.processor_status_word[PSW_CM_HI:PSW_CM_LO];

	// checks
	mode_guard_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		$changed(psw_out) && $past(psw_out[15:14]) == MODE_USER &&
		$past(s_q.st) == PFT_POP2 |-> psw_out[15:14] == MODE_USER)
		else $error("user mode escaped on return");
	regset_keep_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		$past(s_q.st) == PFT_POP2 && $past(psw_out[11]) &&
		$past(psw_out[15:14]) != MODE_KERNEL |-> psw_out[11])
		else $error("register set bit cleared");
	push_step_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.wr && !s_q.swap |-> mem_addr_out == sp_out)
		else $error("push not at predecremented sp");
	trap_seq_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == PFT_VEC1 |=> mem_rd_out ##1 mem_rd_out ##1 s_q.st == PFT_DONE)
		else $error("vector pair not read");
	jump_mode0_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == PFT_IDLE && start_in &&
		(instr_in & MSK_JUMP) == OPC_JUMP && instr_in[5:3] == MODE0
		|=> mem_wr_out ##1 mem_wr_out ##1 s_q.vec == VEC_ILLEGAL)
		else $error("illegal jump not trapped");
	busy_end_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		start_in && !busy_out |-> ##[1:8] (done_out || trace_trap_out))
		else $error("operation did not finish");
	trace_vec_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		trace_trap_out |-> ##2 mem_rd_out && mem_addr_out == VEC_BREAKPOINT)
		else $error("trace trap wrong vector");
	jump_cc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		s_q.st == PFT_IDLE && start_in &&
		(instr_in & MSK_JUMP) == OPC_JUMP && instr_in[5:3] != MODE0
		|=> pc_out == $past(dest_in) && $stable(psw_out))
		else $error("jump wrong target or flags");
	trap_cov_c: cover property (@(posedge mclk_in) s_q.st == PFT_VEC2);
	rti_cov_c: cover property (@(posedge mclk_in) s_q.kind == OPK_RTI &&
		s_q.st == PFT_DONE);
	call_cov_c: cover property (@(posedge mclk_in) s_q.kind == OPK_CALL &&
		s_q.st == PFT_PUSH2);
endmodule : pft_exec

// ===== testbench/pft_mem_model.sv
// pft_mem_model: word store for the stack and the fixed trap vectors
// assumes one clock; read data stand only while the read strobe stands
`timescale 1ns/1ps
module pft_mem_model (
	input wire logic mclk_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out
);
	logic [15:0] mem [logic [15:0]];
	logic [15:0] last_q = 16'h0000;
	// answer in the strobe cycle, otherwise the inverse of the last answer
	always @(rd_in, addr_in, last_q) begin
		if (rd_in)
			rdata_out = mem.exists(addr_in) ? mem[addr_in] : ~addr_in;
		else
			rdata_out = ~last_q;
	end
	// remember the last answer, store writes at the edge
	always @(posedge mclk_in) begin
		if (rd_in)
			last_q <= rdata_out;
		if (wr_in)
			mem[addr_in] = wdata_in;
	end
endmodule : pft_mem_model

// ===== testbench/tb_top.sv
// tb_top: self-checking bench for the program flow and trap block
// assumes internal registers reset to zero and memory never stalls
`timescale 1ns/1ps
module tb_top;
	import pft_pkg::*;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic start_in = 1'b0;
	logic [15:0] instr_in = 16'h0000;
	logic [15:0] dest_in = 16'h0000;
	logic [15:0] rdata, maddr, wdata, pc, processor_status_word, sp;
	logic busy, done, trace, mrd, mwr, dsp;
	logic [1:0] smode;
	int n_errors = 0;
	int n_checks = 0;
	int n_trace = 0;
	logic [15:0] e_pc, e_psw, e_r5, e_r2, v, t, s;
	logic [15:0] e_sp [4];
	logic [15:0] ops [11] = '{16'h8800, 16'h88ff, 16'h8900, 16'h89ff,
		16'h0003, 16'h0004, 16'h0045, 16'h0942, 16'h8800, 16'h8900,
		16'h0007};

	always #25 mclk_in = ~mclk_in;
	// count trace trap starts, data space mark on every memory cycle
	always @(posedge mclk_in) begin
		if (trace === 1'b1)
			n_trace++;
		chk({15'h0000, dsp}, {15'h0000, mrd | mwr});
	end

	pft_exec i_pft_exec (.mclk_in(mclk_in), .srst_in(srst_in),
		.start_in(start_in), .instr_in(instr_in), .dest_in(dest_in),
		.mem_rdata_in(rdata), .busy_out(busy), .done_out(done),
		.trace_trap_out(trace), .mem_rd_out(mrd), .mem_wr_out(mwr),
		.mem_data_space_out(dsp), .mem_addr_out(maddr),
		.mem_wdata_out(wdata), .pc_out(pc), .psw_out(processor_status_word),
		.sp_out(sp), .stack_mode_out(smode));
	pft_mem_model u_mem (.mclk_in(mclk_in), .rd_in(mrd), .wr_in(mwr),
		.addr_in(maddr), .wdata_in(wdata), .rdata_out(rdata));

	function automatic logic [15:0] rnd_even();
		return 16'($urandom) & 16'hfffe;
	endfunction : rnd_even
	function automatic logic [15:0] vec_of(input logic [15:0] op);
		if (op[15:8] == 8'h88)
			return VEC_EMULATOR;
		if (op[15:8] == 8'h89)
			return VEC_SOFTWARE;
		if (op == OPC_BPT)
			return VEC_BREAKPOINT;
		if (op == OPC_IOT)
			return VEC_IO;
		return ((op & MSK_JUMP) == OPC_JUMP) ? VEC_ILLEGAL : VEC_RESERVED;
	endfunction : vec_of
	// status word a return may load from the current mode
	function automatic logic [15:0] ret_psw(input logic [15:0] c,
		input logic [15:0] k);
		logic [15:0] r;
		r = k;
		if (c[15:14] != MODE_KERNEL) begin
			r[15:12] = k[15:12] | {c[15:14], c[15:14]};
			r[11] = k[11] | c[11];
		end
		return r;
	endfunction : ret_psw
	function automatic logic [15:0] loop_pc(input logic [15:0] p,
		input logic [15:0] cnt, input logic [15:0] off);
		return (cnt != 16'h0000) ? p - {off[14:0], 1'b0} : p;
	endfunction : loop_pc

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic st_chk();
		chk(pc, e_pc);
		chk(processor_status_word, e_psw);
		chk(sp, e_sp[e_psw[15:14]]);
		chk(16'(smode), 16'(e_psw[15:14]));
	endtask : st_chk
	// one instruction, then wait until the block stays idle
	task automatic run(input logic [15:0] op, input logic [15:0] d);
		int i, idle, dn;
		idle = 0;
		dn = 0;
		start_in <= 1'b1;
		instr_in <= op;
		dest_in <= d;
		@(posedge mclk_in);
		start_in <= 1'b0;
		for (i = 0; i < 80 && idle < 4; i++) begin
			@(posedge mclk_in);
			idle = (busy === 1'b0) ? idle + 1 : 0;
			dn += (done === 1'b1) ? 1 : 0;
		end
		chk(16'(dn), 16'h0001);
	endtask : run
	// trap with preloaded vector pair, stacked words checked
	task automatic trap(input logic [15:0] op, input logic [15:0] np);
		logic [15:0] a, q, npc;
		a = vec_of(op);
		q = e_sp[e_psw[15:14]] - 16'h0004;
		npc = rnd_even();
		u_mem.mem[a] = npc;
		u_mem.mem[a + 16'h0002] = np;
		run(op, rnd_even());
		chk(u_mem.mem[q + 16'h0002], e_psw);
		chk(u_mem.mem[q], e_pc);
		e_sp[e_psw[15:14]] = q;
		e_pc = npc;
		e_psw = np;
		st_chk();
	endtask : trap
	task automatic ret_int(input logic [15:0] op, input logic [15:0] k);
		logic [15:0] q, npc;
		q = e_sp[e_psw[15:14]];
		npc = rnd_even();
		u_mem.mem[q] = npc;
		u_mem.mem[q + 16'h0002] = k;
		run(op, 16'h0000);
		e_sp[e_psw[15:14]] = q + 16'h0004;
		e_pc = npc;
		e_psw = ret_psw(e_psw, k);
	endtask : ret_int
	// trace trap taken through the breakpoint vector, status cleared
	task automatic traced();
		logic [15:0] q;
		q = e_sp[e_psw[15:14]] - 16'h0004;
		chk(u_mem.mem[q + 16'h0002], e_psw);
		chk(u_mem.mem[q], e_pc);
		e_sp[e_psw[15:14]] = q;
		e_pc = t;
		e_psw = 16'h0000;
		st_chk();
	endtask : traced
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// watchdog far beyond the expected run length
	initial begin
		#(50 * 20000);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(87650));
		e_pc = 16'h0000;
		e_psw = 16'h0000;
		e_r5 = 16'h0000;
		e_r2 = 16'h0000;
		e_sp = '{default: 16'h0000};
		ops[8] = OPC_EMT | 16'($urandom_range(255));
		ops[9] = OPC_SWT | 16'($urandom_range(255));
		repeat (4) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(posedge mclk_in);
		st_chk();
		// every trap kind, opcode range ends and illegal modes
		for (int k = 0; k < 11; k++)
			trap(ops[k], 16'($urandom) & 16'h00ef);
		// jumps in every mode but register mode, codes kept
		for (int m = 1; m < 8; m++) begin
			v = rnd_even();
			run(OPC_JUMP | 16'(m << 3) | 16'($urandom_range(7)), v);
			e_pc = v;
			st_chk();
		end
		// nested calls through register five push the old link
		repeat (3) begin
			v = rnd_even();
			run(OPC_CALL | 16'h0140 | 16'($urandom_range(7, 1) << 3), v);
			e_sp[0] -= 16'h0002;
			chk(u_mem.mem[e_sp[0]], e_r5);
			e_r5 = e_pc;
			e_pc = v;
			st_chk();
		end
		run(OPC_RET | 16'h0005, 16'h0000);
		e_pc = e_r5;
		e_r5 = u_mem.mem[e_sp[0]];
		e_sp[0] += 16'h0002;
		st_chk();
		// mark: stack past the parameters, pc from register five
		t = 16'($urandom_range(63));
		s = e_pc + {t[14:0], 1'b0};
		v = rnd_even();
		u_mem.mem[s] = v;
		run(OPC_MARK | t, 16'h0000);
		e_sp[0] = s + 16'h0002;
		e_pc = e_r5;
		st_chk();
		run(OPC_RET | 16'h0005, 16'h0000);
		e_pc = v;
		e_sp[0] += 16'h0002;
		st_chk();
		// coroutine swap through the stack top, sp unmoved
		v = rnd_even();
		u_mem.mem[e_sp[0]] = v;
		run(16'h09de, v);
		chk(u_mem.mem[e_sp[0]], e_pc);
		e_pc = v;
		st_chk();
		// loop count one falls through, then wraps and branches back
		u_mem.mem[e_sp[0]] = 16'h0001;
		run(OPC_RET | 16'h0002, 16'h0000);
		e_pc = e_r2;
		e_r2 = 16'h0001;
		e_sp[0] += 16'h0002;
		st_chk();
		for (int k = 0; k < 2; k++) begin
			t = (k == 1) ? 16'h003f : 16'($urandom_range(63));
			run(OPC_LOOP | 16'h0080 | t, 16'h0000);
			e_r2 -= 16'h0001;
			e_pc = loop_pc(e_pc, e_r2, t);
			st_chk();
		end
		// interrupt return with trace set traps at once
		t = rnd_even();
		u_mem.mem[VEC_BREAKPOINT] = t;
		u_mem.mem[VEC_BREAKPOINT + 16'h0002] = 16'h0000;
		ret_int(OPC_RTI, 16'h0010);
		chk(16'(n_trace), 16'h0001);
		traced();
		// trap return holds the trace back one instruction
		ret_int(OPC_RTT, 16'h0015);
		chk(16'(n_trace), 16'h0001);
		st_chk();
		v = rnd_even();
		run(OPC_JUMP | 16'h0008, v);
		e_pc = v;
		chk(16'(n_trace), 16'h0002);
		traced();
		// returns from supervisor and user cannot raise privilege, a return from kernel loads its status word unchanged
		trap(OPC_IOT, 16'h4800);
		ret_int(OPC_RTI, 16'h0000);
		st_chk();
		trap(OPC_BPT, 16'hc000);
		ret_int(OPC_RTT, 16'h0000);
		st_chk();
		trap(OPC_EMT, 16'h0000);
		ret_int(OPC_RTI, 16'h3800);
		st_chk();
		tally_and_finish();
	end
endmodule : tb_top
